/* common/imc_pkg.sv */
// Package: register map, lane layout and encodings of the mode control block
package imc_pkg;
  localparam int IMC_NSRC = 8;
  localparam int IMC_LANE_W = 8;
  localparam logic [31:0] IMC_ADDR_MODE0 = 32'hFFFFE000;
  localparam logic [31:0] IMC_ADDR_MODE1 = 32'hFFFFE004;
  localparam logic [31:0] IMC_ADDR_STATUS = 32'hFFFFE010;
  localparam logic [31:0] IMC_ADDR_MASK = 32'hFFFFE014;
  localparam logic [31:0] IMC_ADDR_RAW = 32'hFFFFE018;
  localparam int IMC_LVL_LSB = 0;
  localparam int IMC_DMA_BIT = 4;
  localparam int IMC_COND_LSB = 5;
  localparam logic [7:0] IMC_LANE_WMASK = 8'h77;
  localparam logic [31:0] IMC_RESET_VAL = 32'h00000000;
  localparam logic [2:0] IMC_LVL_OFF = 3'h0;
  typedef enum logic [1:0] {
    IMC_COND_LOW = 2'h0,
    IMC_COND_HIGH = 2'h1,
    IMC_COND_FALL = 2'h2,
    IMC_COND_RISE = 2'h3
  } imc_cond_t;
endpackage

/* common/imc_det_if.sv */
// Interface: lane fields and detected requests between top and detector
`timescale 1ns/1ps
`default_nettype none
interface imc_det_if #(parameter int N = 8);
  logic [N-1:0] req_sync;
  logic [2*N-1:0] cond;
  logic [N-1:0] hit;
  modport top (output req_sync, output cond, input hit);
  modport det (input req_sync, input cond, output hit);
endinterface
`default_nettype wire

/* rtl/imc_detect.sv */
// Module: per-source request detector, level or edge by mode field
`timescale 1ns/1ps
`default_nettype none
module imc_detect
  import imc_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic resetn,
  imc_det_if.det bus
);
  logic [N-1:0] prev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev <= '0;
    end else begin
      prev <= bus.req_sync;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      always_comb begin
        case (imc_cond_t'(bus.cond[2*g +: 2])) // [R1]
          IMC_COND_LOW: bus.hit[g] = !bus.req_sync[g];
          IMC_COND_HIGH: bus.hit[g] = bus.req_sync[g];
          IMC_COND_FALL: bus.hit[g] = prev[g] && !bus.req_sync[g];
          IMC_COND_RISE: bus.hit[g] = !prev[g] && bus.req_sync[g];
          default: bus.hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/imc_top.sv */
// Module: interrupt mode control registers with routing to cpu or dma
//
// Operation
// (R1) Two-bit condition: 00 low, 01 high, 10 falling, 11 rising edge.
// (R2) DMA select bit makes the source a DMA trigger, else not.
// (R3) DMA select clear: level field gives priority, 000 disables, else 1-7.
// (R4) DMA select set: the same field is read as DMA channel.
// (R5) Channel codes 000-011 give channels 0-3, 100-111 channels 4-7.
// (R6) Unused lane bits read zero; all fields reset to zero.
`timescale 1ns/1ps
`default_nettype none
module imc_top
  import imc_pkg::*;
#(
  parameter int N = IMC_NSRC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [N-1:0] req_in,
  output logic [N-1:0] cpu_req,
  output logic [2:0] cpu_level,
  output logic [N-1:0] dma_trig,
  output logic [7:0] dma_ch_req,
  output logic irq
);
  localparam int NW = (N * IMC_LANE_W + 31) / 32;

  logic [N*IMC_LANE_W-1:0] lanes;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] status;
  logic [N-1:0] mask;
  logic [N-1:0] hit;
  logic [N-1:0] next_cpu_req;
  logic [N-1:0] next_dma_trig;
  logic [7:0] next_dma_ch;
  logic [2:0] next_level;
  logic [31:0] next_rdata;

  imc_det_if #(.N(N)) det_bus ();

  function automatic logic [7:0] lane_of(input int i,
      input logic [N*IMC_LANE_W-1:0] l);
    lane_of = l[i*IMC_LANE_W +: IMC_LANE_W];
  endfunction

  function automatic logic word_hit(input logic [31:0] a, input int w);
    word_hit = (a == IMC_ADDR_MODE0 + 32'(w * 4));
  endfunction

  // Request pins pass two flops first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= req_in;
      sync2 <= sync1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lane
      assign det_bus.cond[2*g +: 2] =
        lanes[g*IMC_LANE_W + IMC_COND_LSB +: 2];
    end
  endgenerate
  assign det_bus.req_sync = sync2;
  assign hit = det_bus.hit;

  imc_detect #(.N(N)) u_det (
    .clk(clk),
    .resetn(resetn),
    .bus(det_bus)
  );

  // Mode lanes; reserved bits never stored
  generate
    for (g = 0; g < N; g++) begin : g_reg
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          lanes[g*IMC_LANE_W +: IMC_LANE_W] <= '0; // [R6]
        end else if (wr && word_hit(addr, g / 4)) begin
          lanes[g*IMC_LANE_W +: IMC_LANE_W] <=
            wdata[(g % 4)*IMC_LANE_W +: IMC_LANE_W] & IMC_LANE_WMASK; // [R6]
        end
      end
    end
  endgenerate

  // Routing of each detected request
  always_comb begin
    logic [7:0] ln;
    logic [2:0] fld;
    ln = '0;
    fld = '0;
    next_cpu_req = '0;
    next_dma_trig = '0;
    next_dma_ch = '0;
    next_level = '0;
    for (int i = 0; i < N; i++) begin
      ln = lane_of(i, lanes);
      fld = ln[IMC_LVL_LSB +: 3];
      if (ln[IMC_DMA_BIT]) begin
        next_dma_trig[i] = hit[i]; // [R2]
        if (hit[i]) begin
          next_dma_ch[fld] = 1'b1; // [R4] [R5]
        end
      end else if (fld != IMC_LVL_OFF) begin // [R3]
        next_cpu_req[i] = hit[i];
        if (hit[i] && fld > next_level) begin
          next_level = fld; // [R3]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_req <= '0;
      dma_trig <= '0;
      dma_ch_req <= '0;
      cpu_level <= '0;
    end else begin
      cpu_req <= next_cpu_req;
      dma_trig <= next_dma_trig;
      dma_ch_req <= next_dma_ch;
      cpu_level <= next_level;
    end
  end

  // Sticky status; set beats write-one-to-clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else if (wr && addr == IMC_ADDR_STATUS) begin
      status <= (status & ~wdata[N-1:0]) | next_cpu_req;
    end else begin
      status <= status | next_cpu_req;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask <= '0;
    end else if (wr && addr == IMC_ADDR_MASK) begin
      mask <= wdata[N-1:0];
    end
  end

  // Level output, registered one cycle behind status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_comb begin
    next_rdata = '0;
    for (int w = 0; w < NW; w++) begin
      if (word_hit(addr, w)) begin
        for (int b = 0; b < 4; b++) begin
          if (w * 4 + b < N) begin
            next_rdata[b*IMC_LANE_W +: IMC_LANE_W] =
              lane_of(w * 4 + b, lanes); // [R6]
          end
        end
      end
    end
    if (addr == IMC_ADDR_STATUS) begin
      next_rdata[N-1:0] = status;
    end else if (addr == IMC_ADDR_MASK) begin
      next_rdata[N-1:0] = mask;
    end else if (addr == IMC_ADDR_RAW) begin
      next_rdata[N-1:0] = sync2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= IMC_RESET_VAL;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

/* verification/imc_src.sv */
// Request source model driving the raw request pins
`timescale 1ns/1ps
`default_nettype none
module imc_src (
  input wire logic clk,
  input wire logic [7:0] pat,
  output logic [7:0] req_in
);
  initial req_in = 8'h00;
  always @(posedge clk) begin
    req_in <= pat;
  end
endmodule
`default_nettype wire

/* verification/imc_top_assertions.sv */
// Port checker of the mode control block
`timescale 1ns/1ps
`default_nettype none
module imc_top_assertions
  import imc_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [N-1:0] req_in,
  input wire logic [N-1:0] cpu_req,
  input wire logic [2:0] cpu_level,
  input wire logic [N-1:0] dma_trig,
  input wire logic [7:0] dma_ch_req,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_mode_rd;
    rd && addr == IMC_ADDR_MODE1;
  endsequence
  AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("rdata not idle");
  AST_RSVD: assert property (s_mode_rd |=> (rdata & 32'h88888888) == 0)
    else $error("unused bit set");
  AST_EXCL: assert property ((cpu_req & dma_trig) == '0)
    else $error("cpu and dma both");
  AST_NOLVL: assert property (cpu_req == '0 |-> cpu_level == 3'h0)
    else $error("level without request");
  AST_LVL: assert property (cpu_req != '0 |-> cpu_level != 3'h0)
    else $error("request without level");
  AST_CHAN: assert property (dma_trig != '0 |-> dma_ch_req != 8'h00)
    else $error("trigger without channel");
endmodule
bind imc_top imc_top_assertions #(.N(N)) chk_i (.clk, .resetn, .addr,
  .wdata, .wr, .rd, .rdata, .req_in, .cpu_req, .cpu_level, .dma_trig,
  .dma_ch_req, .irq);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench of the mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import imc_pkg::*;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, irq;
  logic [31:0] addr = 0, wdata = 0, rdata;
  logic [7:0] pat = 0, req_in, cpu_req, dma_trig, dma_ch_req;
  logic [2:0] cpu_level;
  int fail_count = 0, total_checks = 0, cyc = 0;
  logic [31:0] rows [3][2] = '{'{32'hFFFFFFFF, 32'h77777777},
    '{32'h88888888, 32'h0}, '{32'h12345678, 32'h12345670}};
  imc_src imc_src_i (.clk, .pat, .req_in);
  imc_top imc_top_i (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
    .req_in, .cpu_req, .cpu_level, .dma_trig, .dma_ch_req, .irq);
  initial forever #12.5 clk = ~clk;
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task put(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task get(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 cmp(rdata, exp);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    get(IMC_ADDR_MODE1, IMC_RESET_VAL);
    foreach (rows[i]) begin
      put(IMC_ADDR_MODE1, rows[i][0]);
      get(IMC_ADDR_MODE1, rows[i][1]);
    end
    // Last row leaves source 7 as a low-level DMA trigger; park it
    put(IMC_ADDR_MODE1, 32'h0);
    get(32'hFFFFE0F0, 32'h0);
    put(IMC_ADDR_MASK, 32'h4);
    put(IMC_ADDR_MODE0, 32'h36650000);
    pat <= 8'h0C;
    repeat (8) begin
      @(negedge clk);
      if (cpu_req[2] === 1'b1) break;
    end
    cmp(cpu_req, 32'h4);
    cmp(cpu_level, 32'h5);
    cmp(dma_trig, 32'h8);
    cmp(dma_ch_req, 32'h40);
    @(negedge clk);
    cmp(cpu_req, 32'h0);
    cmp(irq, 32'h1);
    get(IMC_ADDR_RAW, 32'hC);
    get(IMC_ADDR_MASK, 32'h4);
    get(IMC_ADDR_STATUS, 32'h4);
    put(IMC_ADDR_STATUS, 32'h4);
    get(IMC_ADDR_STATUS, 32'h0);
    put(IMC_ADDR_MODE0, 32'h36200000);
    repeat (4) @(negedge clk);
    cmp(cpu_req, 32'h0);
    put(IMC_ADDR_MODE0, 32'h36220000);
    repeat (3) @(negedge clk);
    cmp(cpu_level, 32'h2);
    // Clear while the level source still fires: set wins
    put(IMC_ADDR_STATUS, 32'h4);
    get(IMC_ADDR_STATUS, 32'h4);
    for (int c = 0; c < 8; c++) begin
      put(IMC_ADDR_MODE0, {8'h30 | 8'(c), 24'h0});
      repeat (3) @(negedge clk);
      cmp(dma_ch_req, 32'h1 << c);
    end
    // Falling edge on source 2 at level 1
    put(IMC_ADDR_MODE0, 32'h00410000);
    pat <= 8'h08;
    repeat (8) begin
      @(negedge clk);
      if (cpu_req[2] === 1'b1) break;
    end
    cmp(cpu_req, 32'h4);
    cmp(cpu_level, 32'h1);
    @(negedge clk);
    cmp(cpu_req, 32'h0);
    // Low level on source 2 fires while the pin stays low
    put(IMC_ADDR_MODE0, 32'h00010000);
    repeat (3) @(negedge clk);
    cmp(cpu_req, 32'h4);
    // Reset in mid-run clears outputs and fields
    @(posedge clk);
    resetn <= 0;
    @(negedge clk);
    cmp({cpu_req, dma_trig, dma_ch_req, cpu_level, irq}, 32'h0);
    @(posedge clk);
    resetn <= 1;
    get(IMC_ADDR_MODE0, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
